// ---- logic/port_status_pkg.sv ----
// Purpose: Shared constants for the serial port status and mask block.
// Assumes: One 32-bit register word per offset, byte addresses.
// Notes:   Command bit positions follow the port command register layout.
package port_status_pkg;

    // ----------------------------------------------------------------
    // Register offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] OFS_CMD         = 8'h00;
    localparam logic [7:0] OFS_ENABLE_SET  = 8'h08;
    localparam logic [7:0] OFS_DISABLE_CLR = 8'h0C;
    localparam logic [7:0] OFS_MASK_VIEW   = 8'h10;
    localparam logic [7:0] OFS_STATUS      = 8'h14;
    localparam logic [7:0] OFS_RX_HOLD     = 8'h18;
    localparam logic [7:0] OFS_TX_HOLD     = 8'h1C;
    localparam logic [7:0] OFS_RX_TIMEOUT  = 8'h24;

    // ----------------------------------------------------------------
    // Shared bit map of enable, disable, mask and status
    // ----------------------------------------------------------------
    localparam int NUM_SRC          = 11;
    localparam int BIT_RX_READY     = 0;
    localparam int BIT_TX_FREE      = 1;
    localparam int BIT_BREAK        = 2;
    localparam int BIT_RX_END       = 3;
    localparam int BIT_TX_END       = 4;
    localparam int BIT_OVERRUN      = 5;
    localparam int BIT_FRAMING      = 6;
    localparam int BIT_PARITY       = 7;
    localparam int BIT_TIMEOUT      = 8;
    localparam int BIT_TX_DRAINED   = 9;
    localparam int BIT_MODEM_CHANGE = 10;

    // ----------------------------------------------------------------
    // Command register bits
    // ----------------------------------------------------------------
    localparam int CMD_RX_RESET   = 2;
    localparam int CMD_TX_RESET   = 3;
    localparam int CMD_RX_ENABLE  = 4;
    localparam int CMD_RX_DISABLE = 5;
    localparam int CMD_TX_ENABLE  = 6;
    localparam int CMD_TX_DISABLE = 7;
    localparam int CMD_CLEAR_ERR  = 8;
    localparam int CMD_ARM_IDLE   = 11;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [10:0] MASK_RESET   = 11'h000;
    localparam logic [7:0]  TIMEOUT_RST  = 8'h00;
    localparam logic [31:0] STATUS_RESET = 32'h0000_0018;

    // Time-out arming sequence.
    typedef enum logic [1:0] {
        TO_IDLE,
        TO_WAIT_CHAR,
        TO_RUNNING,
        TO_EXPIRED
    } timeout_state_e;

endpackage

// ---- logic/serial_port_status_and_irq_mask.sv ----
// Purpose: Status flags, interrupt mask and status read for a serial port.
// Assumes: Shifters, baud and transfer channels report via event pulses and levels.
// Notes:   Read data stand exactly one cycle after the read strobe.
`timescale 1ns/100ps
`default_nettype none

// Summary of operation
// - Writing one to enable-set turns a source on; zeros change nothing.
// - Writing one to disable-clear turns a source off; zeros do nothing.
// - Mask view shows enabled sources as ones; zero after reset.
// - All four registers share one eleven-bit map; upper bits unused.
// - Receive-ready sets on a character; clears on read or disable.
// - Transmit-free is one when enabled, holding register empty and no break pends.
// - Transmit-free and drained read zero at reset; enable sets both.
// - Break flag sets on break start or end; clear command clears it.
// - Receive-end flag follows the receive transfer channel end signal.
// - Transmit-end flag follows the transmit transfer channel end signal.
// - Overrun sets when a byte lands while receive-ready is set.
// - Framing flag sets on a low stop bit until the clear command.
// - Parity flag sets on bad parity of a received character.
// - Time-out sets on expiry; arm clears it; zero value keeps it clear.
// - Drained is one only with holding and shift empty and no break.
// - Modem-change flag sets on any modem delta change.
// - Clear command clears parity, framing, overrun, break and modem-change flags.
// - Arming starts counting only after the next received character.
module serial_port_status_and_irq_mask
    import port_status_pkg::*;
#(
    parameter int TICK_WIDTH = 8
) (
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_write,
    input  wire logic        reg_read,
    output logic      [31:0] reg_rdata,
    input  wire logic        rx_char_done,
    input  wire logic [8:0]  rx_char_data,
    input  wire logic        rx_stop_low,
    input  wire logic        rx_parity_bad,
    input  wire logic        rx_break_edge,
    input  wire logic        tx_load_shift,
    input  wire logic        tx_shift_busy,
    input  wire logic        tx_break_pending,
    input  wire logic        tx_break_active,
    input  wire logic        rx_block_end,
    input  wire logic        tx_block_end,
    input  wire logic        modem_delta,
    input  wire logic        timeout_tick,
    output logic      [8:0]  tx_holding_reg,
    output logic             tx_holding_full,
    output logic             port_irq
);

    // --------------------------------------------------------------
    // Decode
    // --------------------------------------------------------------
    logic wr_cmd;
    logic wr_en;
    logic wr_dis;
    logic wr_thr;
    logic wr_tor;
    logic rd_rhr;
    logic cmd_clear_err;
    logic cmd_arm;
    logic cmd_tx_on;
    logic cmd_tx_off;
    logic cmd_rx_off;
    logic cmd_rx_on;

    // Strobe qualifiers; any other offset is simply not decoded.
    assign wr_cmd = reg_write && (reg_addr == OFS_CMD);
    assign wr_en  = reg_write && (reg_addr == OFS_ENABLE_SET);
    assign wr_dis = reg_write && (reg_addr == OFS_DISABLE_CLR);
    assign wr_thr = reg_write && (reg_addr == OFS_TX_HOLD);
    assign wr_tor = reg_write && (reg_addr == OFS_RX_TIMEOUT);
    assign rd_rhr = reg_read && (reg_addr == OFS_RX_HOLD);
    assign cmd_clear_err = wr_cmd && reg_wdata[CMD_CLEAR_ERR];
    assign cmd_arm       = (wr_cmd && reg_wdata[CMD_ARM_IDLE]) || wr_tor;
    assign cmd_tx_off    = wr_cmd && (reg_wdata[CMD_TX_DISABLE]
                                      || reg_wdata[CMD_TX_RESET]);
    assign cmd_tx_on     = wr_cmd && reg_wdata[CMD_TX_ENABLE] && !cmd_tx_off;
    assign cmd_rx_off    = wr_cmd && (reg_wdata[CMD_RX_DISABLE]
                                      || reg_wdata[CMD_RX_RESET]);
    assign cmd_rx_on     = wr_cmd && reg_wdata[CMD_RX_ENABLE] && !cmd_rx_off;

    // --------------------------------------------------------------
    // Interrupt mask
    // --------------------------------------------------------------
    logic [NUM_SRC-1:0] mask_q;

    // Set then clear: a bit named in both strobes would need two cycles
    // anyway since the strobes never coincide.
    always_ff @(posedge clk) begin
        if (reset) begin
            mask_q <= MASK_RESET;
        end else if (wr_en) begin
            mask_q <= mask_q | reg_wdata[NUM_SRC-1:0];
        end else if (wr_dis) begin
            mask_q <= mask_q & ~reg_wdata[NUM_SRC-1:0];
        end
    end

    // --------------------------------------------------------------
    // Enables and transmit holding register
    // --------------------------------------------------------------
    logic rx_on_q;
    logic tx_on_q;
    logic thr_full_q;
    logic [8:0] thr_q;

    always_ff @(posedge clk) begin
        if (reset) begin
            rx_on_q <= 1'b0;
        end else if (cmd_rx_off) begin
            rx_on_q <= 1'b0;
        end else if (cmd_rx_on) begin
            rx_on_q <= 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            tx_on_q <= 1'b0;
        end else if (cmd_tx_off) begin
            tx_on_q <= 1'b0;
        end else if (cmd_tx_on) begin
            tx_on_q <= 1'b1;
        end
    end

    // A write lands only while the transmitter runs; the enable command
    // empties the holding register so both transmit flags read one.
    always_ff @(posedge clk) begin
        if (reset) begin
            thr_full_q <= 1'b0;
        end else if (cmd_tx_off || cmd_tx_on) begin
            thr_full_q <= 1'b0;
        end else if (wr_thr && tx_on_q) begin
            thr_full_q <= 1'b1;
        end else if (tx_load_shift) begin
            thr_full_q <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            thr_q <= 9'h000;
        end else if (wr_thr && tx_on_q) begin
            thr_q <= reg_wdata[8:0];
        end
    end

    assign tx_holding_reg  = thr_q;
    assign tx_holding_full = thr_full_q;

    // --------------------------------------------------------------
    // Receive side
    // --------------------------------------------------------------
    logic       rx_ready_q;
    logic [8:0] rhr_q;
    logic       rx_in;

    assign rx_in = rx_char_done && rx_on_q;

    // A new character beats a same-cycle read so it is not lost.
    always_ff @(posedge clk) begin
        if (reset) begin
            rx_ready_q <= 1'b0;
        end else if (cmd_rx_off) begin
            rx_ready_q <= 1'b0;
        end else if (rx_in) begin
            rx_ready_q <= 1'b1;
        end else if (rd_rhr) begin
            rx_ready_q <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            rhr_q <= 9'h000;
        end else if (rx_in) begin
            rhr_q <= rx_char_data;
        end
    end

    // --------------------------------------------------------------
    // Sticky error flags, one instance per flag
    // --------------------------------------------------------------
    logic [3:0] err_set;
    logic [3:0] err_q;

    assign err_set[0] = rx_break_edge;
    assign err_set[1] = rx_in && rx_ready_q;
    assign err_set[2] = rx_in && rx_stop_low;
    assign err_set[3] = rx_in && rx_parity_bad;

    for (genvar g = 0; g < 4; g++) begin : g_err
        sticky_flag u_flag (
            .clk         (clk),
            .reset       (reset),
            .set_pulse   (err_set[g]),
            .clear_pulse (cmd_clear_err),
            .flag_q      (err_q[g])
        );
    end

    logic modem_q;
    sticky_flag u_modem (
        .clk         (clk),
        .reset       (reset),
        .set_pulse   (modem_delta),
        .clear_pulse (cmd_clear_err),
        .flag_q      (modem_q)
    );

    // --------------------------------------------------------------
    // Receive time-out
    // --------------------------------------------------------------
    timeout_state_e          to_state_q;
    logic [TICK_WIDTH-1:0]   to_value_q;
    logic [TICK_WIDTH-1:0]   to_count_q;
    logic                    timeout_flag;

    always_ff @(posedge clk) begin
        if (reset) begin
            to_value_q <= TICK_WIDTH'(TIMEOUT_RST);
        end else if (wr_tor) begin
            to_value_q <= reg_wdata[TICK_WIDTH-1:0];
        end
    end

    // Arm waits for a character, then counts ticks down from the value;
    // every character before expiry reloads the count.
    always_ff @(posedge clk) begin
        if (reset) begin
            to_state_q <= TO_IDLE;
            to_count_q <= '0;
        end else if (cmd_arm) begin
            to_state_q <= TO_WAIT_CHAR;
        end else begin
            case (to_state_q)
                TO_IDLE: begin
                    to_state_q <= TO_IDLE;
                end
                TO_WAIT_CHAR, TO_RUNNING: begin
                    if (rx_in) begin
                        to_state_q <= TO_RUNNING;
                        to_count_q <= to_value_q;
                    end else if ((to_state_q == TO_RUNNING)
                                 && timeout_tick) begin
                        if (to_count_q <= 1) begin
                            to_state_q <= TO_EXPIRED;
                        end
                        to_count_q <= to_count_q - 1'b1;
                    end
                end
                TO_EXPIRED: begin
                    to_state_q <= TO_EXPIRED;
                end
                default: begin
                    to_state_q <= TO_IDLE;
                end
            endcase
        end
    end

    assign timeout_flag = (to_state_q == TO_EXPIRED)
                          && (to_value_q != '0);

    // --------------------------------------------------------------
    // Status word and interrupt
    // --------------------------------------------------------------
    logic [NUM_SRC-1:0] status;

    always_comb begin
        status = '0;
        status[BIT_RX_READY]     = rx_ready_q;
        status[BIT_TX_FREE]      = tx_on_q && !thr_full_q
                                   && !tx_break_pending;
        status[BIT_BREAK]        = err_q[0];
        status[BIT_RX_END]       = rx_block_end;
        status[BIT_TX_END]       = tx_block_end;
        status[BIT_OVERRUN]      = err_q[1];
        status[BIT_FRAMING]      = err_q[2];
        status[BIT_PARITY]       = err_q[3];
        status[BIT_TIMEOUT]      = timeout_flag;
        status[BIT_TX_DRAINED]   = tx_on_q && !thr_full_q && !tx_shift_busy
                                   && !tx_break_active;
        status[BIT_MODEM_CHANGE] = modem_q;
    end

    assign port_irq = |(status & mask_q);

    // Read mux; write-only and unmapped offsets return zero.
    always_ff @(posedge clk) begin
        if (reset) begin
            reg_rdata <= 32'h0000_0000;
        end else if (reg_read) begin
            case (reg_addr)
                OFS_MASK_VIEW: reg_rdata <= {21'h000000, mask_q};
                OFS_STATUS:    reg_rdata <= {21'h000000, status};
                OFS_RX_HOLD:   reg_rdata <= {23'h000000, rhr_q};
                OFS_RX_TIMEOUT: begin
                    reg_rdata <= {24'h000000, 8'(to_value_q)};
                end
                default:       reg_rdata <= 32'h0000_0000;
            endcase
        end else begin
            reg_rdata <= 32'h0000_0000;
        end
    end

    // --------------------------------------------------------------
    // Checks
    // --------------------------------------------------------------
    property p_enable_set;
        @(posedge clk) disable iff (reset)
        wr_en |=> ((mask_q & $past(reg_wdata[NUM_SRC-1:0]))
                   == $past(reg_wdata[NUM_SRC-1:0]));
    endproperty
    a_enable_set: assert property (p_enable_set)
        else $error("enable-set did not turn sources on");

    property p_disable_clr;
        @(posedge clk) disable iff (reset)
        wr_dis |=> ((mask_q & $past(reg_wdata[NUM_SRC-1:0])) == '0)
                   && ((mask_q | $past(reg_wdata[NUM_SRC-1:0]))
                       == ($past(mask_q) | $past(reg_wdata[NUM_SRC-1:0])));
    endproperty
    a_disable_clr: assert property (p_disable_clr)
        else $error("disable-clear wrong");

    property p_mask_read;
        @(posedge clk) disable iff (reset)
        (reg_read && reg_addr == OFS_MASK_VIEW) |=>
            reg_rdata == {21'h000000, $past(mask_q)};
    endproperty
    a_mask_read: assert property (p_mask_read)
        else $error("mask view read wrong");

    property p_overrun;
        @(posedge clk) disable iff (reset)
        (rx_in && rx_ready_q) |=> status[BIT_OVERRUN];
    endproperty
    a_overrun: assert property (p_overrun)
        else $error("overrun not set");

    property p_clear_err;
        @(posedge clk) disable iff (reset)
        (cmd_clear_err && !rx_in && !rx_break_edge) |=>
            !status[BIT_FRAMING] && !status[BIT_PARITY]
            && !status[BIT_BREAK] && !status[BIT_OVERRUN];
    endproperty
    a_clear_err: assert property (p_clear_err)
        else $error("clear command left an error flag");

    property p_tx_enable;
        @(posedge clk) disable iff (reset)
        (cmd_tx_on && !tx_break_pending) |=>
            status[BIT_TX_FREE] || tx_break_pending;
    endproperty
    a_tx_enable: assert property (p_tx_enable)
        else $error("transmit enable did not set ready");

    property p_rx_ready;
        @(posedge clk) disable iff (reset)
        (rd_rhr && !rx_in) |=> !rx_ready_q;
    endproperty
    a_rx_ready: assert property (p_rx_ready)
        else $error("receive-ready not cleared by read");

    // Judged from the flags themselves, not from the OR that drives it.
    property p_irq;
        @(posedge clk) disable iff (reset)
        ((mask_q == '0) |-> !port_irq)
        and ((mask_q[BIT_RX_READY] && rx_ready_q) |-> port_irq);
    endproperty
    a_irq: assert property (p_irq)
        else $error("interrupt output mismatch");

    property p_timeout_arm;
        @(posedge clk) disable iff (reset)
        cmd_arm |=> !timeout_flag ##1 !timeout_flag;
    endproperty
    a_timeout_arm: assert property (p_timeout_arm)
        else $error("time-out flag set right after arming");

    c_overrun: cover property (@(posedge clk) disable iff (reset)
        err_set[1]);
    c_timeout: cover property (@(posedge clk) disable iff (reset)
        timeout_flag);
    c_irq: cover property (@(posedge clk) disable iff (reset)
        port_irq);

endmodule
`default_nettype wire

// ---- logic/sticky_flag.sv ----
// Purpose: One hardware-set, command-cleared sticky status flag.
// Assumes: Set and clear are one-cycle pulses in the clk domain.
// Notes:   A set in the clearing cycle wins so no event is lost.
`timescale 1ns/100ps
`default_nettype none
module sticky_flag (
    input  wire logic clk,
    input  wire logic reset,
    input  wire logic set_pulse,
    input  wire logic clear_pulse,
    output logic      flag_q
);

    // --------------------------------------------------------------
    // Flag storage
    // --------------------------------------------------------------
    // Set takes priority over clear.
    always_ff @(posedge clk) begin
        if (reset) begin
            flag_q <= 1'b0;
        end else if (set_pulse) begin
            flag_q <= 1'b1;
        end else if (clear_pulse) begin
            flag_q <= 1'b0;
        end
    end

endmodule
`default_nettype wire

// ---- verification/line_peer.sv ----
// Purpose: Behavioural serial peer that feeds receive-side events.
// Assumes: Events are one-cycle pulses launched after a rising edge.
// Notes:   Outside a character the data bus shows inverted stale bits.
`timescale 1ns/100ps
`default_nettype none
module line_peer (
    input  wire logic       clk,
    output logic            char_done,
    output logic      [8:0] char_data,
    output logic            stop_low,
    output logic            parity_bad,
    output logic            break_edge,
    output logic            modem_delta
);
    // ------------------------------------------------------------
    // Idle levels
    // ------------------------------------------------------------
    initial begin
        char_done   = 1'b0;
        char_data   = 9'h1FF;
        stop_low    = 1'b1;
        parity_bad  = 1'b1;
        break_edge  = 1'b0;
        modem_delta = 1'b0;
    end

    // One received character; qualifiers go stale afterwards so a
    // design that samples them late sees garbage, not a lucky match.
    task automatic send_char(input logic [8:0] d, input logic sl,
                             input logic pb);
        @(posedge clk);
        char_done  <= 1'b1;
        char_data  <= d;
        stop_low   <= sl;
        parity_bad <= pb;
        @(posedge clk);
        char_done  <= 1'b0;
        char_data  <= ~d;
        stop_low   <= ~sl;
        parity_bad <= ~pb;
    endtask

    // A break edge or a modem status change, as a single pulse.
    task automatic line_event(input logic brk, input logic mdm);
        @(posedge clk);
        break_edge  <= brk;
        modem_delta <= mdm;
        @(posedge clk);
        break_edge  <= 1'b0;
        modem_delta <= 1'b0;
    endtask
endmodule
`default_nettype wire

// ---- verification/serial_port_status_and_irq_mask_test.sv ----
// Purpose: Self-checking bench for the port status and mask block.
// Assumes: Register reads return data one cycle after the strobe.
// Notes:   Receive events come from the peer model, the rest from here.
`timescale 1ns/100ps
`default_nettype none
module serial_port_status_and_irq_mask_test;
    import port_status_pkg::*;
    logic        clk = 1'b0;
    logic        reset = 1'b1;
    logic [7:0]  reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic        reg_write = 1'b0;
    logic        reg_read = 1'b0;
    logic [31:0] reg_rdata;
    logic        rx_char_done, rx_stop_low, rx_parity_bad;
    logic [8:0]  rx_char_data, tx_holding_reg;
    logic        rx_break_edge, modem_delta, tx_holding_full;
    logic        tx_load_shift = 1'b0, tx_shift_busy = 1'b0;
    logic        tx_break_pending = 1'b0, tx_break_active = 1'b0;
    logic        rx_block_end = 1'b1, tx_block_end = 1'b1;
    logic        timeout_tick = 1'b0, port_irq;
    logic [31:0] rd;
    int          failures = 0;
    int          check_count = 0;

    always #4 clk = ~clk;

    line_peer peer (.clk(clk), .char_done(rx_char_done),
        .char_data(rx_char_data), .stop_low(rx_stop_low),
        .parity_bad(rx_parity_bad), .break_edge(rx_break_edge),
        .modem_delta(modem_delta));

    serial_port_status_and_irq_mask uut (.clk(clk), .reset(reset),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .rx_char_done(rx_char_done),
        .rx_char_data(rx_char_data), .rx_stop_low(rx_stop_low),
        .rx_parity_bad(rx_parity_bad), .rx_break_edge(rx_break_edge),
        .tx_load_shift(tx_load_shift), .tx_shift_busy(tx_shift_busy),
        .tx_break_pending(tx_break_pending),
        .tx_break_active(tx_break_active), .rx_block_end(rx_block_end),
        .tx_block_end(tx_block_end), .modem_delta(modem_delta),
        .timeout_tick(timeout_tick), .tx_holding_reg(tx_holding_reg),
        .tx_holding_full(tx_holding_full), .port_irq(port_irq));

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask

    // Writes leave a free cycle after them, so strobes never overlap.
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clk);
        reg_write <= 1'b0;
    endtask

    // Read data are sampled only in the cycle after the strobe.
    task automatic rd_reg(input logic [7:0] a);
        @(posedge clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clk);
        reg_read <= 1'b0;
        #1 rd = reg_rdata;
    endtask

    task automatic stat(input logic [31:0] exp);
        rd_reg(OFS_STATUS);
        check(rd, exp);
    endtask

    task automatic cmd(input int b);
        wr(OFS_CMD, 32'h0000_0001 << b);
    endtask

    task automatic tick();
        @(posedge clk);
        timeout_tick <= 1'b1;
        @(posedge clk);
        timeout_tick <= 1'b0;
    endtask

    task automatic chk_to(input logic exp);
        rd_reg(OFS_STATUS);
        check(32'(rd[BIT_TIMEOUT]), 32'(exp));
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic reset_test();
        stat(STATUS_RESET);
        rd_reg(OFS_MASK_VIEW);
        check(rd, 32'h0000_0000);
        rx_block_end <= 1'b0;
        stat(32'h0000_0010);
        tx_block_end <= 1'b0;
        stat(32'h0000_0000);
        $display("done reset_test");
    endtask

    task automatic mask_test();
        wr(OFS_ENABLE_SET, 32'hFFFF_FFFF);
        rd_reg(OFS_MASK_VIEW);
        check(rd, 32'h0000_07FF);
        wr(OFS_DISABLE_CLR, 32'h0000_00A5);
        wr(OFS_ENABLE_SET, 32'h0000_0000);
        wr(OFS_MASK_VIEW, 32'h0000_0000);
        wr(OFS_STATUS, 32'hFFFF_FFFF);
        rd_reg(OFS_ENABLE_SET);
        check(rd, 32'h0000_0000);
        rd_reg(OFS_DISABLE_CLR);
        check(rd, 32'h0000_0000);
        rd_reg(OFS_MASK_VIEW);
        check(rd, 32'h0000_075A);
        check(32'(port_irq), 32'h0);
        wr(OFS_DISABLE_CLR, 32'hFFFF_FFFF);
        rd_reg(OFS_MASK_VIEW);
        check(rd, 32'h0000_0000);
        $display("done mask_test");
    endtask

    task automatic rx_test();
        cmd(CMD_RX_ENABLE);
        wr(OFS_ENABLE_SET, 32'h0000_0001);
        peer.send_char(9'h1A5, 1'b0, 1'b0);
        stat(32'h0000_0001);
        check(32'(port_irq), 32'h1);
        peer.send_char(9'h05A, 1'b0, 1'b0);
        stat(32'h0000_0021);
        rd_reg(OFS_RX_HOLD);
        check(rd, 32'h0000_005A);
        stat(32'h0000_0020);
        check(32'(port_irq), 32'h0);
        peer.send_char(9'h0F0, 1'b1, 1'b1);
        peer.line_event(1'b1, 1'b0);
        peer.line_event(1'b0, 1'b1);
        stat(32'h0000_04E5);
        cmd(CMD_RX_ENABLE);
        stat(32'h0000_04E5);
        cmd(CMD_CLEAR_ERR);
        stat(32'h0000_0001);
        cmd(CMD_RX_DISABLE);
        stat(32'h0000_0000);
        wr(OFS_DISABLE_CLR, 32'h0000_0001);
        $display("done rx_test");
    endtask

    task automatic tx_test();
        cmd(CMD_TX_ENABLE);
        stat(32'h0000_0202);
        wr(OFS_TX_HOLD, 32'h0000_0133);
        stat(32'h0000_0000);
        check({22'h0, tx_holding_full, tx_holding_reg}, 32'h333);
        tx_load_shift <= 1'b1;
        tx_shift_busy <= 1'b1;
        @(posedge clk);
        tx_load_shift <= 1'b0;
        stat(32'h0000_0002);
        tx_shift_busy    <= 1'b0;
        tx_break_pending <= 1'b1;
        stat(32'h0000_0200);
        tx_break_pending <= 1'b0;
        tx_break_active  <= 1'b1;
        stat(32'h0000_0002);
        tx_break_active <= 1'b0;
        wr(OFS_ENABLE_SET, 32'h0000_0200);
        #1 check(32'(port_irq), 32'h1);
        wr(OFS_DISABLE_CLR, 32'h0000_0200);
        #1 check(32'(port_irq), 32'h0);
        cmd(CMD_TX_DISABLE);
        stat(32'h0000_0000);
        cmd(CMD_TX_ENABLE);
        cmd(CMD_TX_RESET);
        stat(32'h0000_0000);
        $display("done tx_test");
    endtask

    task automatic timeout_test();
        cmd(CMD_RX_ENABLE);
        wr(OFS_RX_TIMEOUT, 32'h0000_0002);
        rd_reg(OFS_RX_TIMEOUT);
        check(rd, 32'h0000_0002);
        repeat (3) tick();
        chk_to(1'b0);
        peer.send_char(9'h011, 1'b0, 1'b0);
        tick();
        chk_to(1'b0);
        tick();
        chk_to(1'b1);
        cmd(CMD_ARM_IDLE);
        chk_to(1'b0);
        peer.send_char(9'h022, 1'b0, 1'b0);
        repeat (2) tick();
        chk_to(1'b1);
        wr(OFS_RX_TIMEOUT, 32'h0000_0000);
        chk_to(1'b0);
        // With a zero value the count runs out on the first tick, yet stays silent.
        peer.send_char(9'h033, 1'b0, 1'b0);
        repeat (2) tick();
        chk_to(1'b0);
        cmd(CMD_RX_RESET);
        stat(32'h0000_0020);
        $display("done timeout_test");
    endtask

    // ------------------------------------------------------------
    // Run control
    // ------------------------------------------------------------
    task automatic close_out();
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // The tests need under two hundred cycles; over twenty times that is a hang.
    initial begin
        repeat (4000) @(posedge clk);
        failures++;
        close_out();
    end

    initial begin
        repeat (6) @(posedge clk);
        reset <= 1'b0;
        reset_test();
        mask_test();
        rx_test();
        tx_test();
        timeout_test();
        close_out();
    end
endmodule
`default_nettype wire
